// file: src/smb_ctrl.sv
// Overview of operation
// - Mode word fields: length, order, latency, op, write.
// - Controller zeroes mode bits above nine and bank.
// - Mode word holds until the next load.
// - Load only with banks idle, then wait.
// - Lengths one to eight both orders; page sequential.
// - Upper column bits pick aligned block; wrap inside.
// - Page burst wraps in row until stopped.
// - Order bit: zero sequential, one interleaved.
// - Sequential offset increments modulo burst length.
// - Interleaved offset is start XOR beat index.
// - Single burst uses full column, ignores order.
// - Read at n drives from n+m-1, valid n+m.
// - Latency two or three; other codes reserved.
// - Controller refuses reserved length, latency and op codes; accepts interleaved page.
// - Both op bits zero select normal operation.
// - Write mode bit makes writes single location.
// - Activate a row before reading or writing.
// - Wait activate-to-column delay, rounded up.
// - Precharge before new row; respect row cycle.
// - Other bank may open; respect row-to-row delay.
// - Mode load with both bank bits low.
// - Load mode before any operational command.
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
module smb_ctrl
    import smb_pkg::*;
#(
    parameter int CNT_W = 8
)
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Memory link
    smb_if.ctl               link
);
    localparam logic [CNT_W-1:0] CMAX = '1;
    localparam logic [CNT_W-1:0] MRD_M1 = CNT_W'(MRD_CYC - 1);
    localparam logic [CNT_W-1:0] RCD_M1 = CNT_W'(RCD_CYC - 1);
    localparam logic [CNT_W-1:0] RC_M1  = CNT_W'(RC_CYC - 1);
    localparam logic [CNT_W-1:0] RRD_M1 = CNT_W'(RRD_CYC - 1);

    initial
    begin
        if (RC_CYC > 2**CNT_W - 1)
            $error("CNT_W too narrow for the timing counts.");
    end

    logic [13:0]       addr_r;
    logic [31:0]       wdata_r;
    logic [31:0]       rdata_r;
    logic [7:0]        rcnt_r;
    logic              err_r;
    logic              mok_r;
    logic [2:0]        pend_r;
    logic [MODE_W-1:0] shadow_r;
    logic [CNT_W-1:0]  sact_r [NBANK];
    logic [CNT_W-1:0]  any_r;
    logic [CNT_W-1:0]  mrd_r;
    logic [NBANK-1:0]  open_r;
    smb_cmd_t          cmd_r;
    logic [BA_W-1:0]   ba_r;
    logic [ADDR_W-1:0] ad_r;
    logic [8:0]        wleft_r;
    logic              wpage_r;
    logic              wr_oe_n_r;
    logic              pready_r;
    logic              pslverr_r;
    logic [31:0]       prdata_r;

    function automatic logic [8:0] beats(input logic [BL_W-1:0] c);
        case (c)
            BL_2:    return 9'h2;
            BL_4:    return 9'h4;
            BL_8:    return 9'h8;
            default: return 9'h1;
        endcase
    endfunction

    // APB decode.
    wire setup  = psel && !penable;
    wire acc_wr = psel && penable && pready_r && pwrite && !pslverr_r;
    wire busy   = (pend_r != 3'(CMD_NOP));
    wire hit    = (paddr == REG_CMD) || (paddr == REG_ADDR) || (paddr == REG_WDATA)
                  || (paddr == REG_RDATA) || (paddr == REG_STATUS);
    wire refuse = !hit || (pwrite && paddr == REG_CMD && busy);
    wire [31:0] status = {16'h0, rcnt_r, 5'h0, err_r, mok_r, busy};
    wire [31:0] rmux = (paddr == REG_ADDR) ? {18'h0, addr_r} :
                       (paddr == REG_WDATA) ? wdata_r :
                       (paddr == REG_RDATA) ? rdata_r :
                       (paddr == REG_STATUS) ? status : 32'h0;

    // Legality of the pending command.
    wire [BA_W-1:0]   pba   = addr_r[AR_BA_LSB +: BA_W];
    wire [MODE_W-1:0] pmode = addr_r[MODE_W-1:0];
    wire [BL_W-1:0]   pbl   = pmode[BL_LSB +: BL_W];
    wire [CL_W-1:0]   pcl   = pmode[CL_LSB +: CL_W];
    wire mode_bad = !(pbl inside {BL_1, BL_2, BL_4, BL_8, BL_PG})
                    || !(pcl inside {CL_2, CL_3})
                    || pmode[OPM_LO] || pmode[OPM_HI]
                    || (open_r != '0);
    wire mrd_ok = (mrd_r >= MRD_M1);
    wire p_mrs  = (pend_r == 3'(CMD_MODE_LOAD));
    wire p_act  = (pend_r == 3'(CMD_ACTIVATE));
    wire p_col  = (pend_r == 3'(CMD_READ)) || (pend_r == 3'(CMD_WRITE));
    wire p_bad  = (p_mrs && mode_bad)
                  || (p_act && (open_r[pba] || !mok_r))
                  || (p_col && (!open_r[pba] || !mok_r));
    wire p_wait = !mrd_ok
                  || (p_act && (sact_r[pba] < RC_M1 || any_r < RRD_M1))
                  || (p_col && sact_r[pba] < RCD_M1);
    wire issue  = busy && !p_bad && !p_wait;
    wire drop   = busy && p_bad;
    wire i_wr   = issue && pend_r == 3'(CMD_WRITE);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= '0;
        end
        else
        begin
            pready_r  <= setup;
            pslverr_r <= setup && refuse;
            prdata_r  <= setup ? rmux : prdata_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            addr_r  <= '0;
            wdata_r <= '0;
            pend_r  <= 3'(CMD_NOP);
            err_r   <= 1'b0;
        end
        else
        begin
            if (acc_wr && paddr == REG_ADDR)
                addr_r <= pwdata[13:0];
            if (acc_wr && paddr == REG_WDATA)
                wdata_r <= pwdata;
            if (acc_wr && paddr == REG_CMD)
                pend_r <= pwdata[2:0];
            else if (issue || drop)
                pend_r <= 3'(CMD_NOP);
            // A refusal in the same cycle as the clear still flags.
            if (drop)
                err_r <= 1'b1;
            else if (acc_wr && paddr == REG_STATUS && pwdata[ST_ERR])
                err_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_r    <= CMD_NOP;
            ba_r     <= '0;
            ad_r     <= '0;
            mok_r    <= 1'b0;
            shadow_r <= '0;
            open_r   <= '0;
        end
        else
        begin
            cmd_r <= issue ? smb_cmd_t'(pend_r) : CMD_NOP;
            ba_r  <= (issue && !p_mrs) ? pba : '0;
            ad_r  <= !issue ? '0 :
                     p_mrs ? ADDR_W'(pmode) : addr_r[ADDR_W-1:0];
            if (issue && p_mrs)
            begin
                mok_r    <= 1'b1;
                shadow_r <= pmode;
            end
            if (issue && p_act)
                open_r[pba] <= 1'b1;
            else if (issue && pend_r == 3'(CMD_PRECHARGE) && addr_r[PALL_BIT])
                open_r <= '0;
            else if (issue && pend_r == 3'(CMD_PRECHARGE))
                open_r[pba] <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            any_r <= CMAX;
            mrd_r <= CMAX;
            for (int b = 0; b < NBANK; b++)
                sact_r[b] <= CMAX;
        end
        else
        begin
            any_r <= (issue && p_act) ? '0 : (any_r == CMAX ? CMAX : any_r + 1'b1);
            mrd_r <= (issue && p_mrs) ? '0 : (mrd_r == CMAX ? CMAX : mrd_r + 1'b1);
            for (int b = 0; b < NBANK; b++)
                sact_r[b] <= (issue && p_act && pba == BA_W'(b)) ? '0 :
                             (sact_r[b] == CMAX ? CMAX : sact_r[b] + 1'b1);
        end
    end

    // Write data rides alongside the command and each later beat.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wleft_r   <= '0;
            wpage_r   <= 1'b0;
            wr_oe_n_r <= 1'b1;
        end
        else if (i_wr)
        begin
            wleft_r   <= shadow_r[WBM_BIT] ? 9'h1 : beats(shadow_r[BL_LSB +: BL_W]);
            wpage_r   <= !shadow_r[WBM_BIT] && shadow_r[BL_LSB +: BL_W] == BL_PG;
            wr_oe_n_r <= 1'b0;
        end
        else if (issue)
        begin
            wleft_r   <= '0;
            wpage_r   <= 1'b0;
            wr_oe_n_r <= 1'b1;
        end
        else if (wleft_r != '0 && !wpage_r)
        begin
            wleft_r   <= wleft_r - 1'b1;
            wr_oe_n_r <= (wleft_r == 9'h1);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rdata_r <= '0;
            rcnt_r  <= '0;
        end
        else if (!link.dev_dq_oe_n)
        begin
            rdata_r <= link.dq;
            rcnt_r  <= rcnt_r + 1'b1;
        end
    end

    assign link.cmd         = cmd_r;
    assign link.ba          = ba_r;
    assign link.addr        = ad_r;
    assign link.ctl_dq_o    = wdata_r;
    assign link.ctl_dq_oe_n = wr_oe_n_r;
    assign pready           = pready_r;
    assign pslverr          = pslverr_r;
    assign prdata           = prdata_r;
endmodule // smb_ctrl

// file: src/smb_pkg.sv
package smb_pkg;
    // Link widths.
    localparam int DQ_W   = 32;
    localparam int ADDR_W = 12;
    localparam int COL_W  = 8;
    localparam int BA_W   = 2;
    localparam int NBANK  = 4;
    localparam int MODE_W = 10;
    // Mode word layout.
    localparam int BL_LSB  = 0;
    localparam int BL_W    = 3;
    localparam int BT_BIT  = 3;
    localparam int CL_LSB  = 4;
    localparam int CL_W    = 3;
    localparam int OPM_LO  = 7;
    localparam int OPM_HI  = 8;
    localparam int WBM_BIT = 9;
    localparam int PALL_BIT = 10;
    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_PG = 3'h7;
    localparam logic [2:0] CL_2 = 3'h2;
    localparam logic [2:0] CL_3 = 3'h3;
    typedef enum logic [2:0] {
        CMD_NOP, CMD_MODE_LOAD, CMD_ACTIVATE, CMD_READ,
        CMD_WRITE, CMD_BURST_STOP, CMD_PRECHARGE
    } smb_cmd_t;
    // Timing.
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_MRD_NS = 20;
    localparam int T_RCD_NS = 20;
    localparam int T_RC_NS  = 70;
    localparam int T_RRD_NS = 15;
    function automatic int ns_to_cyc(input int ns);
        return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction
    localparam int MRD_CYC = ns_to_cyc(T_MRD_NS);
    localparam int RCD_CYC = ns_to_cyc(T_RCD_NS);
    localparam int RC_CYC  = ns_to_cyc(T_RC_NS);
    localparam int RRD_CYC = ns_to_cyc(T_RRD_NS);
    // Controller register map.
    localparam logic [7:0] REG_CMD    = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_WDATA  = 8'h08;
    localparam logic [7:0] REG_RDATA  = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam int ST_BUSY = 0;
    localparam int ST_MODE = 1;
    localparam int ST_ERR  = 2;
    localparam int ST_CNT_LSB = 8;
    localparam int AR_BA_LSB = 12;
endpackage

// file: src/smb_if.sv
`timescale 1ns/1ns
interface smb_if;
    import smb_pkg::*;
    smb_cmd_t          cmd;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0]   ctl_dq_o;
    logic              ctl_dq_oe_n;
    logic [DQ_W-1:0]   dev_dq_o;
    logic              dev_dq_oe_n;
    logic [DQ_W-1:0]   dq;
    // Nobody driving reads as zero.
    assign dq = !dev_dq_oe_n ? dev_dq_o : (!ctl_dq_oe_n ? ctl_dq_o : '0);
    modport ctl (output cmd, ba, addr, ctl_dq_o, ctl_dq_oe_n, input dq, dev_dq_oe_n);
    modport dev (input cmd, ba, addr, dq, output dev_dq_o, dev_dq_oe_n);
endinterface

// file: src/smb_burst_seq.sv
`timescale 1ns/1ns
module smb_burst_seq
    import smb_pkg::*;
(
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Burst start and stop
    input  wire logic             start,
    input  wire logic             skip_first,
    input  wire logic             stop,
    input  wire logic [COL_W-1:0] start_col,
    input  wire logic [BL_W-1:0]  len_code,
    input  wire logic             order_il,
    // Current column
    output logic                  active,
    output logic [COL_W-1:0]      col
);
    logic [COL_W-1:0] base_r;
    logic [COL_W-1:0] k_r;
    logic [COL_W-1:0] mask_r;
    logic             il_r;
    logic             page_r;
    logic             active_r;

    function automatic logic [COL_W-1:0] len_mask(input logic [BL_W-1:0] c);
        case (c)
            BL_2:    return COL_W'(1);
            BL_4:    return COL_W'(3);
            BL_8:    return COL_W'(7);
            BL_PG:   return '1;
            default: return '0;
        endcase
    endfunction

    wire [COL_W-1:0] st_mask = len_mask(len_code);
    wire [COL_W-1:0] off_seq = (base_r + k_r) & mask_r;
    wire [COL_W-1:0] off_il  = (base_r ^ k_r) & mask_r;
    wire             last    = !page_r && (k_r == mask_r);
    // Page bursts have no interleaved form, so order is forced sequential.
    wire             st_il   = order_il && (len_code != BL_PG);

    assign col    = (base_r & ~mask_r) | (il_r ? off_il : off_seq);
    assign active = active_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            base_r   <= '0;
            k_r      <= '0;
            mask_r   <= '0;
            il_r     <= 1'b0;
            page_r   <= 1'b0;
            active_r <= 1'b0;
        end
        else if (start)
        begin
            base_r   <= start_col;
            mask_r   <= st_mask;
            il_r     <= st_il;
            page_r   <= (len_code == BL_PG);
            k_r      <= skip_first ? COL_W'(1) : '0;
            active_r <= !(skip_first && (st_mask == '0));
        end
        else if (stop || (active_r && last))
            active_r <= 1'b0;
        else if (active_r)
            k_r <= k_r + COL_W'(1);
    end
endmodule // smb_burst_seq

// file: src/smb_sdram_dev.sv
`timescale 1ns/1ns
module smb_sdram_dev
    import smb_pkg::*;
#(
    parameter int ROW_KEEP_W = ADDR_W
)
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Memory link
    smb_if.dev               link,
    // Observed state
    output logic [MODE_W-1:0] mode_q,
    output logic [NBANK-1:0]  bank_open_q
);
    localparam int MEM_AW = BA_W + ROW_KEEP_W + COL_W;

    initial
    begin
        if (ROW_KEEP_W < 1 || ROW_KEEP_W > ADDR_W)
            $error("ROW_KEEP_W must lie between 1 and ADDR_W.");
    end

    logic [MODE_W-1:0]     mode_r;
    logic [NBANK-1:0]      open_r;
    logic [ADDR_W-1:0]     row_r [NBANK];
    logic [BA_W-1:0]       bank_r;
    logic                  rd_r;
    logic                  s1_v_r;
    logic [DQ_W-1:0]       s1_d_r;
    logic [DQ_W-1:0]       dq_o_r;
    logic                  dq_oe_n_r;
    // Storage is trimmed to the kept row bits to bound simulation memory.
    logic [DQ_W-1:0]       mem [2**MEM_AW];
    logic                  seq_act;
    logic [COL_W-1:0]      seq_col;

    function automatic logic [MEM_AW-1:0] midx(input logic [BA_W-1:0] b,
                                               input logic [ADDR_W-1:0] r,
                                               input logic [COL_W-1:0] c);
        return {b, r[ROW_KEEP_W-1:0], c};
    endfunction

    // Mode word decode.
    wire [BL_W-1:0] bl_code = mode_r[BL_LSB +: BL_W];
    wire            bt_il   = mode_r[BT_BIT];
    wire [CL_W-1:0] cl_code = mode_r[CL_LSB +: CL_W];
    wire            wbm     = mode_r[WBM_BIT];
    // Reserved latency codes fall back to two cycles.
    wire            cl3     = (cl_code == CL_3);
    wire            normal  = !mode_r[OPM_LO] && !mode_r[OPM_HI];

    // Command decode.
    wire is_mrs = (link.cmd == CMD_MODE_LOAD) && (link.ba == '0);
    wire is_act = (link.cmd == CMD_ACTIVATE);
    wire is_pre = (link.cmd == CMD_PRECHARGE);
    wire is_rd  = (link.cmd == CMD_READ) && normal && open_r[link.ba];
    wire is_wr  = (link.cmd == CMD_WRITE) && normal && open_r[link.ba];
    wire is_bst = (link.cmd == CMD_BURST_STOP);
    wire [BL_W-1:0] len_sel = (is_wr && wbm) ? BL_1 : bl_code;

    smb_burst_seq u_seq (
        .pclk       (pclk),
        .presetn    (presetn),
        .start      (is_rd || is_wr),
        .skip_first (is_wr),
        .stop       (is_bst || is_pre),
        .start_col  (link.addr[COL_W-1:0]),
        .len_code   (len_sel),
        .order_il   (bt_il),
        .active     (seq_act),
        .col        (seq_col)
    );

    // Write data is taken with the command itself, then once per beat; a beat
    // that meets a stop, precharge or read command is dropped, not written.
    wire              bw_en  = seq_act && !rd_r && !(is_bst || is_pre || is_rd);
    wire              wr_en  = is_wr || bw_en;
    wire [MEM_AW-1:0] wr_idx = is_wr ?
                               midx(link.ba, row_r[link.ba], link.addr[COL_W-1:0]) :
                               midx(bank_r, row_r[bank_r], seq_col);
    wire              rd_beat = seq_act && rd_r;
    wire [DQ_W-1:0]   rd_word = mem[midx(bank_r, row_r[bank_r], seq_col)];

    always_ff @(posedge pclk)
    begin
        if (wr_en)
            mem[wr_idx] <= link.dq;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode_r <= '0;
        else if (is_mrs)
            mode_r <= link.addr[MODE_W-1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            open_r <= '0;
            for (int b = 0; b < NBANK; b++)
                row_r[b] <= '0;
        end
        else if (is_act)
        begin
            open_r[link.ba] <= 1'b1;
            row_r[link.ba]  <= link.addr;
        end
        else if (is_pre && link.addr[PALL_BIT])
            open_r <= '0;
        else if (is_pre)
            open_r[link.ba] <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bank_r <= '0;
            rd_r   <= 1'b0;
        end
        else if (is_rd || is_wr)
        begin
            bank_r <= link.ba;
            rd_r   <= is_rd;
        end
    end

    // Beat 0 leaves the array the cycle after the read command; one
    // pipeline stage adds the third latency cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_v_r    <= 1'b0;
            s1_d_r    <= '0;
            dq_o_r    <= '0;
            dq_oe_n_r <= 1'b1;
        end
        else
        begin
            s1_v_r    <= rd_beat;
            s1_d_r    <= rd_word;
            dq_o_r    <= cl3 ? s1_d_r : rd_word;
            dq_oe_n_r <= !(cl3 ? s1_v_r : rd_beat);
        end
    end

    assign link.dev_dq_o    = dq_o_r;
    assign link.dev_dq_oe_n = dq_oe_n_r;
    assign mode_q           = mode_r;
    assign bank_open_q      = open_r;
endmodule // smb_sdram_dev

// file: testbench/smb_link_props.sv
`timescale 1ns/1ns
module smb_link_props
    import smb_pkg::*;
(
    input wire logic              pclk,
    input wire logic              presetn,
    input smb_cmd_t               cmd,
    input wire logic [BA_W-1:0]   ba,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic              dev_dq_oe_n,
    input wire logic              ctl_dq_oe_n,
    input wire logic [MODE_W-1:0] mode_q,
    input wire logic [NBANK-1:0]  bank_open_q
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A read in a reserved operating mode is ignored, so only normal reads are timed.
    wire rd_ok = cmd == CMD_READ && bank_open_q[ba] && mode_q[OPM_HI:OPM_LO] == 2'h0;
    wire cl2   = mode_q[6:4] == CL_2;
    wire cl3   = mode_q[6:4] == CL_3;
    sequence s_start;
        dev_dq_oe_n ##1 !dev_dq_oe_n;
    endsequence
    sequence s_end;
        !dev_dq_oe_n ##1 dev_dq_oe_n;
    endsequence
    AST_MODE_LOAD: assert property (
        cmd == CMD_MODE_LOAD && ba == '0 && bank_open_q == '0
        |=> mode_q == $past(addr[MODE_W-1:0]))
        else $error("mode word not loaded");
    AST_MODE_HOLD: assert property (cmd != CMD_MODE_LOAD |=> $stable(mode_q))
        else $error("mode word changed without load");
    AST_MODE_FMT: assert property (cmd == CMD_MODE_LOAD
        |-> ba == '0 && addr[11:10] == 2'h0 && bank_open_q == '0)
        else $error("mode load with bad bank or bits");
    AST_MRD: assert property (cmd == CMD_MODE_LOAD |=> cmd == CMD_NOP)
        else $error("command too soon after mode load");
    AST_RRD: assert property (cmd == CMD_ACTIVATE |=> cmd != CMD_ACTIVATE)
        else $error("activates too close");
    AST_RCD: assert property (cmd == CMD_ACTIVATE
        |=> !(cmd inside {CMD_READ, CMD_WRITE} && ba == $past(ba)))
        else $error("column command too soon after activate");
    AST_OPEN: assert property (cmd inside {CMD_READ, CMD_WRITE} |-> bank_open_q[ba])
        else $error("column command to closed bank");
    AST_CL2: assert property (rd_ok && cl2 |-> ##1 s_start)
        else $error("latency two onset wrong");
    AST_CL3: assert property (rd_ok && cl3 |-> ##1 dev_dq_oe_n ##1 s_start)
        else $error("latency three onset wrong");
    AST_BL4: assert property (rd_ok && cl2 && mode_q[2:0] == BL_4
        |-> ##2 (!dev_dq_oe_n)[*3] ##1 s_end)
        else $error("burst of four length wrong");
    AST_BL1: assert property (rd_ok && cl3 && mode_q[2:0] == BL_1 |-> ##3 s_end)
        else $error("single burst length wrong");
    AST_WR1: assert property (cmd == CMD_WRITE && mode_q[WBM_BIT]
        |-> !ctl_dq_oe_n ##1 ctl_dq_oe_n)
        else $error("write not single location");
endmodule // smb_link_props

// file: testbench/sdram_mode_burst_activation_bench.sv
`timescale 1ns/1ns
module sdram_mode_burst_activation_bench;
    import smb_pkg::*;
    logic              pclk = 0;
    logic              presetn = 0;
    logic              psel = 0;
    logic              penable = 0;
    logic              pwrite = 0;
    logic [7:0]        paddr = '0;
    logic [31:0]       pwdata = '0;
    logic [31:0]       prdata;
    logic [31:0]       rq;
    logic              pready;
    logic              pslverr;
    logic              re;
    logic [MODE_W-1:0] mode_q;
    logic [NBANK-1:0]  bank_open_q;
    logic [31:0]       beats[$];
    int                mismatches = 0;
    int                comparisons = 0;
    smb_if link ();
    always #5 pclk = ~pclk;
    smb_ctrl u_smb_ctrl (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .link(link));
    smb_sdram_dev #(.ROW_KEEP_W(2)) u_smb_sdram_dev (.pclk(pclk), .presetn(presetn),
        .link(link), .mode_q(mode_q), .bank_open_q(bank_open_q));
    smb_link_props u_smb_link_props (.pclk(pclk), .presetn(presetn), .cmd(link.cmd),
        .ba(link.ba), .addr(link.addr), .dev_dq_oe_n(link.dev_dq_oe_n),
        .ctl_dq_oe_n(link.ctl_dq_oe_n), .mode_q(mode_q), .bank_open_q(bank_open_q));
    // Beats are taken at the edge that ends each driven cycle.
    always @(posedge pclk)
        if (link.dev_dq_oe_n === 1'b0)
            beats.push_back(link.dq);
    task automatic end_sim;
        if (mismatches == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            mismatches++;
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic op(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a);
        int n;
        apb(1, REG_ADDR, {18'h0, b, a});
        apb(1, REG_CMD, {29'h0, c});
        n = 0;
        do
        begin
            apb(0, REG_STATUS, 32'h0);
            n++;
        end while (rq[ST_BUSY] !== 1'b0 && n < 40);
        if (n >= 40)
            mismatches++;
    endtask
    task automatic t_refuse;
        logic [11:0] bad[3];
        bad = '{12'h224, 12'h012, 12'h0a2};
        foreach (bad[k])
        begin
            op(CMD_MODE_LOAD, 2'h0, bad[k]);
            apb(0, REG_STATUS, 32'h0);
            chk("err", 32'h1, rq[ST_ERR]);
            apb(1, REG_STATUS, 32'h4);
        end
        chk("mode", 32'h0, mode_q);
        apb(0, 8'h40, 32'h0);
        chk("pslverr", 32'h1, re);
    endtask
    // Single-location writes give each column its own word, so burst order is visible.
    task automatic t_fill;
        op(CMD_MODE_LOAD, 2'h0, 12'h222);
        chk("mode", 32'h222, mode_q);
        op(CMD_ACTIVATE, 2'h1, 12'h0);
        for (int k = 4; k < 8; k++)
        begin
            apb(1, REG_WDATA, 32'hd0000000 | k);
            op(CMD_WRITE, 2'h1, k[11:0]);
        end
    endtask
    task automatic t_burst(input logic [11:0] m, input logic [7:0] c, input int n,
                           input logic [31:0] cols);
        int i;
        logic [7:0] cnt;
        op(CMD_PRECHARGE, 2'h0, 12'h400);
        op(CMD_MODE_LOAD, 2'h0, m);
        op(CMD_ACTIVATE, 2'h1, 12'h0);
        beats = {};
        apb(0, REG_STATUS, 32'h0);
        cnt = rq[ST_CNT_LSB +: 8];
        op(CMD_READ, 2'h1, {4'h0, c});
        i = 0;
        while (beats.size() < n && i < 50)
        begin
            @(posedge pclk);
            i++;
        end
        repeat (6) @(posedge pclk);
        chk("beats", n, beats.size());
        for (i = 0; i < n; i++)
            chk("dq", {24'hd00000, cols[8*i +: 8]}, beats[i]);
        apb(0, REG_STATUS, 32'h0);
        chk("count", 8'(cnt + n), rq[ST_CNT_LSB +: 8]);
        apb(0, REG_RDATA, 32'h0);
        chk("rdata", {24'hd00000, cols[8*n-8 +: 8]}, rq);
    endtask
    // A page write from column 8 runs until stopped, so a page read from
    // column 4 shows the four filled words and then the repeated word.
    task automatic t_page;
        int s;
        op(CMD_PRECHARGE, 2'h0, 12'h400);
        op(CMD_MODE_LOAD, 2'h0, 12'h02f);
        op(CMD_ACTIVATE, 2'h1, 12'h0);
        apb(1, REG_WDATA, 32'hd00000ee);
        op(CMD_WRITE, 2'h1, 12'h008);
        op(CMD_BURST_STOP, 2'h1, 12'h0);
        beats = {};
        op(CMD_READ, 2'h1, 12'h004);
        repeat (10) @(posedge pclk);
        op(CMD_BURST_STOP, 2'h1, 12'h0);
        repeat (4) @(posedge pclk);
        s = beats.size();
        repeat (8) @(posedge pclk);
        chk("stopped", s, beats.size());
        chk("run", 1, s > 8);
        for (int i = 0; i < 8; i++)
            chk("page", i < 4 ? 32'hd0000004 + i : 32'hd00000ee, beats[i]);
    endtask
    initial
    begin
        #200000;
        mismatches++;
        end_sim;
    end
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        t_refuse;
        t_fill;
        t_burst(12'h022, 8'h05, 4, 32'h04070605);
        t_burst(12'h03a, 8'h05, 4, 32'h06070405);
        t_burst(12'h038, 8'h06, 1, 32'h00000006);
        t_page;
        end_sim;
    end
endmodule // sdram_mode_burst_activation_bench
